// ==== clk_gate_pkg.sv ====
/*
 * Constants, types and helpers shared by the sleep-mode clock gating block.
 * Assumes a 32-bit AXI4-Lite register bus and six gated peripheral modules.
 */
package clk_gate_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_RUN_GATE = 12'h108;
    localparam logic [11:0] OFF_SLEEP_GATE = 12'h118;
    localparam logic [11:0] OFF_DEEP_GATE = 12'h128;
    localparam logic [11:0] OFF_CLK_CFG = 12'h200;
    localparam logic [11:0] OFF_INT_STATUS = 12'h204;
    localparam logic [11:0] OFF_INT_MASK = 12'h208;
    localparam logic [11:0] OFF_GATE_STATE = 12'h20C;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int N_MOD = 6;
    localparam int BIT_DMA = 13;
    localparam int BIT_PORT_E = 4;
    localparam int BIT_PORT_A = 0;
    localparam int BIT_AUTO_GATE = 0;
    localparam logic [31:0] GATE_RW_MASK = 32'h0000201F;
    localparam logic [31:0] REG_RESET = 32'h00000000;
    localparam logic [5:0] MOD_NONE = 6'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PM_RUN = 2'b00,
        PM_SLEEP = 2'b01,
        PM_DEEP = 2'b10
    } power_mode_e;

    // One enable per gated module, also the layout of interrupt status and mask
    typedef struct packed {
        logic dma;
        logic port_e;
        logic port_d;
        logic port_c;
        logic port_b;
        logic port_a;
    } module_vec_s;

    function automatic module_vec_s reg_to_mod(input logic [31:0] r);
        reg_to_mod = {r[BIT_DMA], r[BIT_PORT_E:BIT_PORT_A]};
    endfunction : reg_to_mod

endpackage : clk_gate_pkg

// ==== clock_gate_cell.sv ====
/*
 * Latch-based clock gating cell for one module clock.
 * Assumes the enable changes only on the rising edge of the source clock.
 */
`timescale 1ns/100ps
module clock_gate_cell (
    input wire logic i_clk,
    input wire logic i_en,
    output logic o_gclk
);

    logic en_latch;

    // ------------------------------------------------------------
    // Gating
    // ------------------------------------------------------------
    // Transparent while the clock is low, so the enable can never cut a high phase short
    always_latch begin
        if (!i_clk) begin
            en_latch = i_en;
        end
    end

    assign o_gclk = i_clk & en_latch;

endmodule : clock_gate_cell

// ==== periph_model.sv ====
/*
 * Behavioural model of the six peripheral modules that receive the gated clocks.
 * Assumes each gated clock has the same period as the system clock while enabled.
 */
`timescale 1ns/100ps
module periph_model
    import clk_gate_pkg::*;
#(
    parameter real HALF_NS = 10.0
) (
    input wire logic [N_MOD-1:0] i_gclk,
    input wire logic i_clr,
    output wire [N_MOD-1:0][7:0] o_edges,
    output wire [N_MOD-1:0] o_short
);
    // ------------------------------------------------------------
    // Per-module edge counter and pulse-width watch
    // ------------------------------------------------------------
    for (genvar m = 0; m < N_MOD; m++) begin : g_mod
        logic [7:0] cnt = 8'h00;
        logic short_hi = 1'h0;
        real t_rise = 0.0;
        // A stopped module sees no edges at all
        always @(posedge i_gclk[m] or posedge i_clr) begin
            if (i_clr) begin
                cnt <= 8'h00;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
        always @(posedge i_gclk[m]) begin
            t_rise = $realtime;
        end
        // A truncated high phase would clock a flop with a runt pulse
        always @(negedge i_gclk[m]) begin
            if (t_rise > 0.0 && $realtime - t_rise < HALF_NS - 0.05) begin
                short_hi = 1'h1;
            end
        end
        assign o_edges[m] = cnt;
        assign o_short[m] = short_hi;
    end
endmodule : periph_model

// ==== sleep_clock_gating.sv ====
/*
 * Power-mode clock gating for the micro-DMA engine and ports A to E,
 * with an AXI4-Lite register slave, access fault flags and an interrupt.
 * Assumes I_POWER_MODE and I_ACCESS_REQ are synchronous to I_CLOCK.
 */
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps

module sleep_clock_gating
    import clk_gate_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_RST_B,
    input wire logic [ADDR_W-1:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [ADDR_W-1:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    input wire logic [1:0] I_POWER_MODE,
    input wire logic [N_MOD-1:0] I_ACCESS_REQ,
    output logic [N_MOD-1:0] O_ACCESS_FAULT,
    output logic [N_MOD-1:0] O_MODULE_EN,
    output logic [N_MOD-1:0] O_MODULE_CLK,
    output logic O_IRQ
);

    logic [31:0] run_clock_gate_ctrl;
    logic [31:0] sleep_clock_gate_ctrl;
    logic [31:0] deep_sleep_clock_gate_ctrl;
    logic auto_gating_select;
    module_vec_s int_status;
    module_vec_s int_mask;
    module_vec_s eff_en;
    module_vec_s next_eff_en;
    module_vec_s fault_evt;
    module_vec_s status_clr;
    power_mode_e mode;

    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic do_write;
    logic wr_hit;
    logic [31:0] byte_mask;
    logic [31:0] rd_word;
    logic rd_hit;
    logic ar_take;

    // ------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------
    always_comb begin
        unique case (I_POWER_MODE)
            PM_RUN: mode = PM_RUN;
            PM_SLEEP: mode = PM_SLEEP;
            PM_DEEP: mode = PM_DEEP;
            default: mode = PM_RUN;
        endcase
    end

    // Without automatic gating both sleep modes keep the run enables
    always_comb begin
        next_eff_en = reg_to_mod(run_clock_gate_ctrl);
        unique case (mode)
            PM_SLEEP: begin
                if (auto_gating_select) begin
                    next_eff_en = reg_to_mod(sleep_clock_gate_ctrl);
                end
            end
            PM_DEEP: begin
                if (auto_gating_select) begin
                    next_eff_en = reg_to_mod(deep_sleep_clock_gate_ctrl);
                end
            end
            default: next_eff_en = reg_to_mod(run_clock_gate_ctrl);
        endcase
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            eff_en <= MOD_NONE;
            O_MODULE_EN <= MOD_NONE;
        end else begin
            eff_en <= next_eff_en;
            O_MODULE_EN <= next_eff_en;
        end
    end

    // ------------------------------------------------------------
    // Gated clocks
    // ------------------------------------------------------------
    // The gated clocks are the one place where an output leaves a gate, not a flop
    generate
        for (genvar g = 0; g < N_MOD; g++) begin : g_gate
            clock_gate_cell u_gate (
                .i_clk(I_CLOCK),
                .i_en(eff_en[g]),
                .o_gclk(O_MODULE_CLK[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Access faults and interrupt
    // ------------------------------------------------------------
    assign fault_evt = I_ACCESS_REQ & ~eff_en;
    assign status_clr = (ar_take && ({I_ARADDR[11:2], 2'b00} == OFF_INT_STATUS)) ?
        module_vec_s'({N_MOD{1'b1}}) : MOD_NONE;

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_ACCESS_FAULT <= MOD_NONE;
            int_status <= MOD_NONE;
            O_IRQ <= 1'b0;
        end else begin
            O_ACCESS_FAULT <= fault_evt;
            // A fault in the cycle of the clearing read survives
            int_status <= (int_status & ~status_clr) | fault_evt;
            O_IRQ <= |(((int_status & ~status_clr) | fault_evt) & int_mask);
        end
    end

    // ------------------------------------------------------------
    // Write channels
    // ------------------------------------------------------------
    assign do_write = aw_full && w_full && !O_BVALID;
    assign wr_hit = ({wr_addr[11:2], 2'b00} == OFF_RUN_GATE) ||
        ({wr_addr[11:2], 2'b00} == OFF_SLEEP_GATE) ||
        ({wr_addr[11:2], 2'b00} == OFF_DEEP_GATE) ||
        ({wr_addr[11:2], 2'b00} == OFF_CLK_CFG) ||
        ({wr_addr[11:2], 2'b00} == OFF_INT_STATUS) ||
        ({wr_addr[11:2], 2'b00} == OFF_INT_MASK) ||
        ({wr_addr[11:2], 2'b00} == OFF_GATE_STATE);

    generate
        for (genvar b = 0; b < 4; b++) begin : g_strb
            assign byte_mask[8*b +: 8] = {8{wr_strb[b]}};
        end
    endgenerate

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            O_AWREADY <= 1'b0;
            O_WREADY <= 1'b0;
            wr_addr <= '0;
            wr_data <= REG_RESET;
            wr_strb <= 4'h0;
        end else begin
            if (O_AWREADY && I_AWVALID) begin
                aw_full <= 1'b1;
                O_AWREADY <= 1'b0;
                wr_addr <= I_AWADDR;
            end else if (do_write) begin
                aw_full <= 1'b0;
            end else if (!aw_full && !O_BVALID) begin
                O_AWREADY <= 1'b1;
            end
            if (O_WREADY && I_WVALID) begin
                w_full <= 1'b1;
                O_WREADY <= 1'b0;
                wr_data <= I_WDATA;
                wr_strb <= I_WSTRB;
            end else if (do_write) begin
                w_full <= 1'b0;
            end else if (!w_full && !O_BVALID) begin
                O_WREADY <= 1'b1;
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_BVALID <= 1'b0;
            O_BRESP <= RESP_OKAY;
        end else if (do_write) begin
            O_BVALID <= 1'b1;
            O_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (O_BVALID && I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            run_clock_gate_ctrl <= REG_RESET;
            sleep_clock_gate_ctrl <= REG_RESET;
            deep_sleep_clock_gate_ctrl <= REG_RESET;
            auto_gating_select <= 1'b0;
            int_mask <= MOD_NONE;
        end else if (do_write) begin
            unique case ({wr_addr[11:2], 2'b00})
                OFF_RUN_GATE: run_clock_gate_ctrl <= ((run_clock_gate_ctrl & ~byte_mask) |
                    (wr_data & byte_mask)) & GATE_RW_MASK;
                OFF_SLEEP_GATE: sleep_clock_gate_ctrl <= ((sleep_clock_gate_ctrl & ~byte_mask) |
                    (wr_data & byte_mask)) & GATE_RW_MASK;
                OFF_DEEP_GATE: deep_sleep_clock_gate_ctrl <=
                    ((deep_sleep_clock_gate_ctrl & ~byte_mask) |
                    (wr_data & byte_mask)) & GATE_RW_MASK;
                OFF_CLK_CFG: begin
                    if (wr_strb[0]) begin
                        auto_gating_select <= wr_data[BIT_AUTO_GATE];
                    end
                end
                OFF_INT_MASK: begin
                    if (wr_strb[0]) begin
                        int_mask <= wr_data[N_MOD-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    assign ar_take = O_ARREADY && I_ARVALID;

    always_comb begin
        rd_word = REG_RESET;
        rd_hit = 1'b1;
        unique case ({I_ARADDR[11:2], 2'b00})
            OFF_RUN_GATE: rd_word = run_clock_gate_ctrl;
            OFF_SLEEP_GATE: rd_word = sleep_clock_gate_ctrl & GATE_RW_MASK;
            OFF_DEEP_GATE: rd_word = deep_sleep_clock_gate_ctrl;
            OFF_CLK_CFG: rd_word[BIT_AUTO_GATE] = auto_gating_select;
            OFF_INT_STATUS: rd_word[N_MOD-1:0] = int_status;
            OFF_INT_MASK: rd_word[N_MOD-1:0] = int_mask;
            OFF_GATE_STATE: rd_word[N_MOD-1:0] = eff_en;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= REG_RESET;
            O_RRESP <= RESP_OKAY;
        end else if (ar_take) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b1;
            O_RDATA <= rd_word;
            O_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (O_RVALID && I_RREADY) begin
            O_RVALID <= 1'b0;
        end else if (!O_RVALID) begin
            O_ARREADY <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RST_B);

    logic rd_sleep_q;
    logic out_of_reset;

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rd_sleep_q <= 1'b0;
            out_of_reset <= 1'b0;
        end else begin
            out_of_reset <= 1'b1;
            if (ar_take) begin
                rd_sleep_q <= ({I_ARADDR[11:2], 2'b00} == OFF_SLEEP_GATE);
            end
        end
    end

    sequence s_sleep_auto;
        (I_POWER_MODE == PM_SLEEP) && auto_gating_select;
    endsequence

    sequence s_sources_quiet;
        ($stable(run_clock_gate_ctrl) && $stable(sleep_clock_gate_ctrl) &&
            $stable(deep_sleep_clock_gate_ctrl) && $stable(auto_gating_select) &&
            $stable(I_POWER_MODE)) [*2];
    endsequence

    sequence s_sleep_write;
        do_write && ({wr_addr[11:2], 2'b00} == OFF_SLEEP_GATE) && (wr_strb == 4'hF);
    endsequence

    a_sleep_select: assert property (
        s_sleep_auto |=> (eff_en == reg_to_mod($past(sleep_clock_gate_ctrl))))
        else $error("sleep enables not applied in sleep mode");

    a_run_fallback: assert property (
        (I_POWER_MODE == PM_SLEEP) && !auto_gating_select
        |=> (eff_en == reg_to_mod($past(run_clock_gate_ctrl))))
        else $error("run enables not kept without automatic gating");

    a_deep_select: assert property (
        (I_POWER_MODE == PM_DEEP) && auto_gating_select
        |=> (O_MODULE_EN == reg_to_mod($past(deep_sleep_clock_gate_ctrl))))
        else $error("deep-sleep enables not applied");

    a_enable_steady: assert property (
        s_sources_quiet |-> $stable(O_MODULE_EN))
        else $error("module enable moved without cause");

    a_fault_gated: assert property (
        (I_ACCESS_REQ & ~eff_en) != MOD_NONE |=> (O_ACCESS_FAULT == ($past(I_ACCESS_REQ) &
            ~$past(eff_en))) && ((int_status & O_ACCESS_FAULT) == O_ACCESS_FAULT))
        else $error("access to stopped module not faulted");

    a_fault_none: assert property (
        (I_ACCESS_REQ & ~eff_en) == MOD_NONE |=> O_ACCESS_FAULT == MOD_NONE)
        else $error("fault raised for a clocked module");

    a_reset_clear: assert property (
        !out_of_reset |-> (sleep_clock_gate_ctrl == REG_RESET) && (eff_en == MOD_NONE))
        else $error("enables not clear after reset");

    a_dma_bit: assert property (
        s_sleep_write
        |=> sleep_clock_gate_ctrl[BIT_DMA] == $past(wr_data[BIT_DMA]))
        else $error("dma enable not stored at bit 13");

    a_port_bits: assert property (
        s_sleep_write |=> sleep_clock_gate_ctrl[BIT_PORT_E:BIT_PORT_A] ==
            $past(wr_data[BIT_PORT_E:BIT_PORT_A]))
        else $error("port enables not stored at bits 4 to 0");

    a_reserved_zero: assert property (
        O_RVALID && rd_sleep_q |-> (O_RDATA & ~GATE_RW_MASK) == REG_RESET)
        else $error("reserved bits read non-zero");

    a_irq_level: assert property (
        ((int_status & int_mask) != MOD_NONE) && !status_clr.dma |=> O_IRQ)
        else $error("interrupt not raised for unmasked status");

endmodule : sleep_clock_gating

// ==== tb.sv ====
/*
 * Self-checking bench for the sleep-mode clock gating block.
 * Assumes the AXI4-Lite and access-fault timing of the block's register slave.
 */
`timescale 1ns/100ps
module tb import clk_gate_pkg::*; ();
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic [ADDR_W-1:0] awaddr = 12'h000;
    logic [ADDR_W-1:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [1:0] mode = PM_RUN;
    logic [N_MOD-1:0] access_req = 6'h00;
    logic clr = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [N_MOD-1:0] fault, mod_en, mod_clk, short_seen;
    logic [N_MOD-1:0][7:0] edges;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    localparam logic CFG_TAB [6] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
    localparam logic [1:0] MODE_TAB [6] = '{PM_SLEEP, PM_SLEEP, PM_DEEP, PM_RUN, 2'h3, PM_DEEP};
    localparam logic [5:0] EN_TAB [6] = '{6'h11, 6'h22, 6'h04, 6'h11, 6'h11, 6'h11};

    always #10 clk = ~clk;

    sleep_clock_gating u_dut (
        .I_CLOCK(clk), .I_RST_B(rst_b), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
        .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
        .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_POWER_MODE(mode),
        .I_ACCESS_REQ(access_req), .O_ACCESS_FAULT(fault), .O_MODULE_EN(mod_en),
        .O_MODULE_CLK(mod_clk), .O_IRQ(irq)
    );

    periph_model u_periph (.i_gclk(mod_clk), .i_clr(clr), .o_edges(edges), .o_short(short_seen));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        if (bad_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_t, w_t, b_t;
        logic [1:0] resp;
        b_t = 1'h0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!b_t) begin
            @(negedge clk);
            aw_t = awvalid && awready === 1'h1;
            w_t = wvalid && wready === 1'h1;
            b_t = bvalid === 1'h1;
            resp = bresp;
            @(posedge clk);
            if (aw_t) awvalid <= 1'h0;
            if (w_t) wvalid <= 1'h0;
        end
        bready <= 1'h0;
        check({30'h0, resp}, {30'h0, er});
    endtask : wr

    // Data of a refused read is left unchecked
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic ar_t, r_t;
        logic [31:0] d;
        logic [1:0] resp;
        r_t = 1'h0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!r_t) begin
            @(negedge clk);
            ar_t = arvalid && arready === 1'h1;
            r_t = rvalid === 1'h1;
            d = rdata;
            resp = rresp;
            @(posedge clk);
            if (ar_t) arvalid <= 1'h0;
        end
        rready <= 1'h0;
        check({30'h0, resp}, {30'h0, er});
        if (er === RESP_OKAY) check(d, exp);
    endtask : rd

    // ------------------------------------------------------------
    // Timeout and main sequence
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'h1;
        repeat (2) @(posedge clk);
        rd(OFF_SLEEP_GATE, REG_RESET, RESP_OKAY);
        rd(OFF_GATE_STATE, 32'h0, RESP_OKAY);
        wr(OFF_SLEEP_GATE, 32'hFFFFFFFF, RESP_OKAY);
        rd(OFF_SLEEP_GATE, 32'h0000201F, RESP_OKAY);
        for (int b = 0; b < 32; b++) begin
            wr(OFF_SLEEP_GATE, 32'h1 << b, RESP_OKAY);
            rd(OFF_SLEEP_GATE, (32'h1 << b) & 32'h0000201F, RESP_OKAY);
        end
        // Byte 0 only: the micro-DMA bit in byte 1 must keep its old value
        wstrb <= 4'h1;
        wr(OFF_SLEEP_GATE, 32'hFFFFFFFF, RESP_OKAY);
        wstrb <= 4'hF;
        rd(OFF_SLEEP_GATE, 32'h0000001F, RESP_OKAY);
        wr(12'h300, 32'h1, RESP_SLVERR);
        rd(12'h300, 32'h0, RESP_SLVERR);
        wr(OFF_RUN_GATE, 32'h00000011, RESP_OKAY);
        wr(OFF_SLEEP_GATE, 32'h00002002, RESP_OKAY);
        wr(OFF_DEEP_GATE, 32'h00000004, RESP_OKAY);
        for (int k = 0; k < 6; k++) begin
            wr(OFF_CLK_CFG, {31'h0, CFG_TAB[k]}, RESP_OKAY);
            mode <= MODE_TAB[k];
            repeat (3) @(posedge clk);
            @(negedge clk);
            check({26'h0, mod_en}, {26'h0, EN_TAB[k]});
            rd(OFF_GATE_STATE, {26'h0, EN_TAB[k]}, RESP_OKAY);
        end
        wr(OFF_CLK_CFG, 32'h1, RESP_OKAY);
        mode <= PM_SLEEP;
        clr <= 1'h1;
        @(posedge clk);
        clr <= 1'h0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        for (int m = 0; m < N_MOD; m++) begin
            check({31'h0, (6'h22 >> m) & 6'h1 ? edges[m] >= 8 : edges[m] == 0}, 32'h1);
        end
        check({26'h0, short_seen}, 32'h0);
        // Status is read-only to writes, so this must not add bits
        wr(OFF_INT_STATUS, 32'h3F, RESP_OKAY);
        for (int k = 0; k < 2; k++) begin
            mode <= k ? PM_RUN : PM_SLEEP;
            wr(OFF_INT_MASK, k ? 32'h3F : 32'h0, RESP_OKAY);
            access_req <= 6'h3F;
            @(posedge clk);
            access_req <= 6'h00;
            @(negedge clk);
            check({26'h0, fault}, k ? 32'h2E : 32'h1D);
            check({31'h0, irq}, k);
            @(negedge clk);
            check({26'h0, fault}, 32'h0);
            rd(OFF_INT_STATUS, k ? 32'h2E : 32'h1D, RESP_OKAY);
            rd(OFF_INT_STATUS, 32'h0, RESP_OKAY);
            check({31'h0, irq}, 32'h0);
        end
        finish_test();
    end
endmodule : tb
